// ===== hw/sac_adc_control.sv
// Control, timing and register logic of the 8-bit successive-approximation converter.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sac_defines.svh"

// How it works
// R1 - Writing one to the start bit begins converting the selected channel.
// R2 - The start bit clears itself once the conversion has begun.
// R3 - Channel codes 0 to 7 pick inputs zero to seven; codes 8 to 15 are reserved.
// R4 - Analog input disable bit: zero enables inputs, one disables them.
// R5 - Software writes one to bit 5 and zero to bit 6 of control one.
// R6 - Software changes the channel only while the busy flag is zero.
// R7 - Ladder connects only during conversion when zero, always when one.
// R8 - Time codes 000,010..110 give 39,78,156,312,624,1248 clocks; 001,111 reserved.
// R9 - Software writes zero to bit 0 and one to bit 4 of control two.
// R10 - Bits 6 and 7 of control two read as undefined values.
// R11 - On completion store the result, set the end flag and raise the interrupt.
// R12 - Reading the result register clears the end flag.
// R13 - A new start clears the end flag but keeps the old result until completion.
// R14 - Busy rises at start, falls at completion and on entry to low power.
// R15 - Low power resets both control registers and blocks writes to them.
// R16 - Software does not restart while a conversion is in progress.
// R17 - Status bits 7, 6 and 3 to 0 are unstable; only end and busy matter.
// R18 - Software programs only time codes permitted for its clock frequency.
// R19 - Low power abandons a conversion, which does not restart on return.
// R20 - A counter times each conversion for exactly the selected clock periods.
// R21 - The interrupt is a one-cycle pulse on the edge that sets the end flag.
module sac_adc_control (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address and data.
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Power management, high during stop, slow or sleep.
    input wire logic low_power_mode,
    // Analog front end.
    input wire logic [7:0] analog_result,
    output logic [3:0] channel_select,
    output logic channel_valid,
    output logic analog_input_off,
    output logic ladder_connect,
    output logic converter_busy,
    // Interrupt controller.
    output logic conversion_done_irq
);

    sac_pkg::sac_state_t s_q;
    sac_pkg::sac_state_t s_d;
    logic rd_result;

    // ------------------------------------------------------------------------
    // Conversion length lookup
    // ------------------------------------------------------------------------
    // Reserved codes run the longest time so a stray setting never undersamples.
    function automatic logic [10:0] conv_cycles(input logic [2:0] code);
        logic [10:0] len;
        case (code)
            3'h0: len = `SAC_CONV_39;
            3'h2: len = `SAC_CONV_78;
            3'h3: len = `SAC_CONV_156;
            3'h4: len = `SAC_CONV_312;
            3'h5: len = `SAC_CONV_624;
            default: len = `SAC_CONV_1248;
        endcase
        return len;
    endfunction

    // Register read view; the fixed bits of control two and the unstable bits read as constants, control one bits 6 and 5 as written.
    function automatic logic [7:0] read_view(input sac_pkg::sac_state_t s, input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            `SAC_ADDR_CTL_ONE: v = {s.go, s.c1_top, s.ain_off, s.chan};
            `SAC_ADDR_CTL_TWO: v = `SAC_C2_FIXED | {2'h0, s.ladder_on, 1'h0, s.ack, 1'h0}; // R10
            `SAC_ADDR_RESULT: v = s.result;
            `SAC_ADDR_STATUS: v = {2'h0, s.done, s.conv == sac_pkg::SAC_RUN, 4'h0}; // R17
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // The order of the blocks below sets priority: bus clears first, then
    // converter events, so a completion in the cycle of a result read wins.
    always_comb begin
        s_d = s_q;
        rd_result = 1'b0;
        s_d.done_irq = 1'b0;
        // Write channel capture; address and data may come in either order.
        if (awvalid && s_q.aw_rdy) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && s_q.w_rdy) begin
            s_d.w_got = 1'b1;
            s_d.w_data = wdata[7:0];
            s_d.w_strb0 = wstrb[0];
        end
        if (bready && s_q.bvalid) begin
            s_d.bvalid = 1'b0;
        end
        // Perform a write once both halves are present.
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `SAC_RESP_OKAY;
            case (s_q.aw_addr)
                `SAC_ADDR_CTL_ONE: begin
                    if (s_q.w_strb0) begin
                        s_d.go = s_q.w_data[`SAC_C1_GO_BIT]; // R1
                        s_d.ain_off = s_q.w_data[`SAC_C1_AIN_OFF_BIT]; // R4
                        s_d.chan = s_q.w_data[3:0];
                        // Bits 6 and 5 keep what software wrote; they leave reset as zero.
                        s_d.c1_top = s_q.w_data[6:5];
                    end
                end
                `SAC_ADDR_CTL_TWO: begin
                    if (s_q.w_strb0) begin
                        s_d.ladder_on = s_q.w_data[`SAC_C2_LADDER_BIT];
                        s_d.ack = s_q.w_data[3:1];
                    end
                end
                `SAC_ADDR_RESULT, `SAC_ADDR_STATUS: begin
                    s_d.bresp = `SAC_RESP_OKAY;
                end
                default: begin
                    s_d.bresp = `SAC_RESP_DECERR;
                end
            endcase
        end
        // Read channel; one read in flight, answered the cycle after the request.
        if (rready && s_q.rvalid) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.ar_rdy) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = read_view(s_q, araddr);
            case (araddr)
                `SAC_ADDR_CTL_ONE, `SAC_ADDR_CTL_TWO, `SAC_ADDR_STATUS: s_d.rresp = `SAC_RESP_OKAY;
                `SAC_ADDR_RESULT: begin
                    s_d.rresp = `SAC_RESP_OKAY;
                    rd_result = 1'b1;
                    s_d.done = 1'b0; // R12
                end
                default: s_d.rresp = `SAC_RESP_DECERR;
            endcase
        end
        // Converter sequencing.
        case (s_q.conv)
            sac_pkg::SAC_IDLE: begin
                if (s_q.go) begin
                    s_d.go = 1'b0; // R2
                    s_d.conv = sac_pkg::SAC_RUN; // R14
                    s_d.count = conv_cycles(s_q.ack) - 11'h001; // R8 R20
                    s_d.done = 1'b0; // R13
                end
            end
            sac_pkg::SAC_RUN: begin
                // A start written mid-run is dropped; software must not do that.
                s_d.go = 1'b0; // R16
                if (s_q.count == 11'h000) begin
                    s_d.conv = sac_pkg::SAC_IDLE; // R14
                    s_d.result = analog_result; // R11
                    s_d.done = 1'b1; // R11
                    s_d.done_irq = 1'b1; // R21
                end else begin
                    s_d.count = s_q.count - 11'h001; // R20
                end
            end
            default: begin
                s_d.conv = sac_pkg::SAC_IDLE;
            end
        endcase
        // Low power overrides everything: controls reset, writes lost, run abandoned.
        if (low_power_mode) begin
            s_d.go = 1'b0; // R15
            s_d.ain_off = 1'b1; // R15
            s_d.chan = 4'h0;
            s_d.c1_top = 2'h0;
            s_d.ladder_on = 1'b0;
            s_d.ack = 3'h0;
            s_d.conv = sac_pkg::SAC_IDLE; // R14 R19
            s_d.count = 11'h000;
            s_d.result = 8'h00; // R19
            s_d.done = 1'b0;
            s_d.done_irq = 1'b0;
        end
        // Output-facing flops derived from the next state.
        s_d.ladder = s_d.ladder_on || (s_d.conv == sac_pkg::SAC_RUN); // R7
        s_d.chan_ok = !s_d.chan[3]; // R3
        s_d.aw_rdy = !s_d.aw_got && !s_d.bvalid;
        s_d.w_rdy = !s_d.w_got && !s_d.bvalid;
        s_d.ar_rdy = !s_d.rvalid;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.ain_off <= 1'b1;
            s_q.chan_ok <= 1'b1;
            s_q.aw_rdy <= 1'b1;
            s_q.w_rdy <= 1'b1;
            s_q.ar_rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Ports straight from the state flops.
    assign awready = s_q.aw_rdy;
    assign wready = s_q.w_rdy;
    assign arready = s_q.ar_rdy;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign rvalid = s_q.rvalid;
    assign rdata = {24'h000000, s_q.rdata};
    assign rresp = s_q.rresp;
    assign channel_select = s_q.chan;
    assign channel_valid = s_q.chan_ok;
    assign analog_input_off = s_q.ain_off;
    assign ladder_connect = s_q.ladder;
    assign converter_busy = s_q.conv == sac_pkg::SAC_RUN;
    assign conversion_done_irq = s_q.done_irq;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    // Helper: measure each run and remember the length that was asked for.
    logic [10:0] run_len_q;
    logic [10:0] exp_len_q;
    logic rd_result_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_len_q <= 11'h000;
            exp_len_q <= 11'h000;
            rd_result_q <= 1'b0;
        end else begin
            rd_result_q <= rd_result;
            if (s_q.go && s_q.conv == sac_pkg::SAC_IDLE) begin
                run_len_q <= 11'h000;
                exp_len_q <= conv_cycles(s_q.ack);
            end else if (s_q.conv == sac_pkg::SAC_RUN) begin
                run_len_q <= run_len_q + 11'h001;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence start_seen_s;
        s_q.go && !low_power_mode && s_q.conv == sac_pkg::SAC_IDLE;
    endsequence
    sequence run_begun_s;
        converter_busy && !s_q.go && !s_q.done;
    endsequence

    start_run_a: assert property (start_seen_s |=> run_begun_s) // R1
        else $error("start bit did not begin a conversion");
    go_self_clear_a: assert property (s_q.go && !low_power_mode |=> !s_q.go) // R2
        else $error("start bit did not clear itself");
    run_length_a: assert property (conversion_done_irq |-> run_len_q == exp_len_q) // R20
        else $error("conversion length differs from selected time");
    irq_pulse_a: assert property (conversion_done_irq |-> s_q.done && !converter_busy ##1 !conversion_done_irq) // R21
        else $error("interrupt not a single pulse with end flag");
    done_cause_a: assert property ($rose(s_q.done) |-> conversion_done_irq && $past(converter_busy)) // R11
        else $error("end flag set without completion");
    read_clear_a: assert property (rd_result_q && !conversion_done_irq |-> !s_q.done) // R12
        else $error("result read did not clear end flag");
    result_hold_a: assert property ($changed(s_q.result) |-> conversion_done_irq || $past(low_power_mode)) // R13
        else $error("result changed outside completion");
    low_power_a: assert property (low_power_mode |=> !converter_busy && s_q.chan == 4'h0 && s_q.ain_off && !s_q.go) // R15
        else $error("low power did not reset controls");
    ladder_run_a: assert property (converter_busy |-> ladder_connect) // R7
        else $error("ladder open during conversion");
    ladder_idle_a: assert property (!converter_busy && !s_q.ladder_on |-> !ladder_connect) // R7
        else $error("ladder connected while idle and not forced");

    // ------------------------------------------------------------------------
    // Read-back, power and handshake checks
    // ------------------------------------------------------------------------
    // Helper: remember which register the standing read answer belongs to; the
    // read view is taken one edge before the answer shows, hence $past below.
    logic [7:0] rd_addr_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr_q <= 8'h00;
        end else if (arvalid && s_q.ar_rdy) begin
            rd_addr_q <= araddr;
        end
    end

    // A fresh answer to a status read; only the first cycle of it is judged,
    // because the flags may move on while the answer waits for rready.
    sequence status_answer_s;
        $rose(rvalid) && rd_addr_q == `SAC_ADDR_STATUS;
    endsequence

    // Status answers carry the live flags and zero in every unstable bit.
    status_flags_a: assert property (status_answer_s |-> // R14
        rdata[5] == $past(s_q.done) && rdata[4] == $past(converter_busy))
        else $error("status flags differ from converter state");
    status_quiet_a: assert property (rvalid && rd_addr_q == `SAC_ADDR_STATUS |-> // R17
        rdata[7:6] == 2'h0 && rdata[3:0] == 4'h0)
        else $error("unstable status bits not held at zero");
    // Control two keeps its undefined top bits quiet as well.
    ctl_two_top_a: assert property (rvalid && rd_addr_q == `SAC_ADDR_CTL_TWO |-> rdata[7:6] == 2'h0) // R10
        else $error("undefined control two bits not held at zero");
    // The valid flag must track the reserved half of the channel codes.
    chan_valid_a: assert property (channel_valid == !channel_select[3]) // R3
        else $error("channel valid flag disagrees with channel code");
    // Busy falls on the very edge that raises the completion pulse.
    busy_end_a: assert property (conversion_done_irq |-> $fell(converter_busy)) // R14
        else $error("busy did not fall with the completion pulse");
    // Low power drops a run with no pulse and no result, and resets control two.
    abandon_a: assert property (low_power_mode |=> !conversion_done_irq && !s_q.done && s_q.result == 8'h00) // R19
        else $error("low power did not abandon the conversion");
    low_power_two_a: assert property (low_power_mode |=> !s_q.ladder_on && s_q.ack == 3'h0) // R15
        else $error("low power did not reset control two");
    // A standing write response blocks new write addresses and data.
    write_wait_a: assert property (bvalid |-> !awready && !wready)
        else $error("write channels ready while a response stands");

endmodule

// ===== hw/sac_defines.svh
// Offsets, field positions, reset values and conversion counts of the converter control block.
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define SAC_IDX_CTL_ONE 8'h0e
`define SAC_IDX_CTL_TWO 8'h0f
`define SAC_IDX_RESULT 8'h20
`define SAC_IDX_STATUS 8'h21
`define SAC_ADDR_CTL_ONE 8'h38
`define SAC_ADDR_CTL_TWO 8'h3c
`define SAC_ADDR_RESULT 8'h80
`define SAC_ADDR_STATUS 8'h84

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SAC_C1_GO_BIT 7
`define SAC_C1_AIN_OFF_BIT 4
`define SAC_C2_LADDER_BIT 5
`define SAC_ST_DONE_BIT 5
`define SAC_ST_BUSY_BIT 4
`define SAC_C1_RESET 8'h10
`define SAC_C2_RESET 8'h10
`define SAC_C1_FIXED 8'h20
`define SAC_C2_FIXED 8'h10

// ----------------------------------------------------------------------------
// Conversion lengths in system clock periods
// ----------------------------------------------------------------------------
`define SAC_CONV_39 11'h027
`define SAC_CONV_78 11'h04e
`define SAC_CONV_156 11'h09c
`define SAC_CONV_312 11'h138
`define SAC_CONV_624 11'h270
`define SAC_CONV_1248 11'h4e0

// AXI response codes.
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_DECERR 2'h3

`endif

// ===== hw/sac_pkg.sv
// Types shared by the converter control block.
package sac_pkg;

    // Converter sequencing states.
    typedef enum logic [0:0] {
        SAC_IDLE = 1'b0,
        SAC_RUN = 1'b1
    } sac_conv_t;

    // Whole state of the control block.
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_strb0;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic go;
        logic ain_off;
        logic [3:0] chan;
        logic [1:0] c1_top;
        logic ladder_on;
        logic [2:0] ack;
        sac_conv_t conv;
        logic [10:0] count;
        logic [7:0] result;
        logic done;
        logic done_irq;
        logic ladder;
        logic chan_ok;
    } sac_state_t;

endpackage

// ===== verification/sac_analog_model.sv
// Behavioural analog front end that feeds results to the converter control block.
`timescale 1ns/1ps
module sac_analog_model (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Converter side.
    input wire logic [3:0] channel_select,
    input wire logic conversion_done_irq,
    output logic [7:0] analog_result
);
    logic [3:0] seq_q;

    // Count finished conversions modulo 16, so a stale result matches a fresh one only after the count wraps.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_q <= 4'h0;
        end else if (conversion_done_irq) begin
            seq_q <= seq_q + 4'h1;
        end
    end

    // The value tells which channel was sampled and at which conversion.
    assign analog_result = {channel_select, seq_q};
endmodule

// ===== verification/sac_adc_control_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_adc_control_tb;
    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, low_power_mode;
    logic awready, wready, bvalid, arready, rvalid;
    logic channel_valid, analog_input_off, ladder_connect, converter_busy, conversion_done_irq;
    logic [7:0] awaddr, araddr, analog_result, rd_q;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, channel_select;
    logic [1:0] bresp, rresp, resp_q;
    logic [10:0] run_len = 11'h000;
    logic [10:0] last_len = 11'h000;
    logic [10:0] conv_len [8] = '{`SAC_CONV_1248, `SAC_CONV_1248, `SAC_CONV_624, `SAC_CONV_312,
                                   `SAC_CONV_156, `SAC_CONV_78, `SAC_CONV_1248, `SAC_CONV_39};
    int irq_cnt, fail_count, n_compared, exp_k;

    sac_adc_control i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .low_power_mode, .analog_result, .channel_select, .channel_valid,
        .analog_input_off, .ladder_connect, .converter_busy, .conversion_done_irq);
    sac_analog_model i_front (.aclk, .aresetn, .channel_select, .conversion_done_irq, .analog_result);

    // Free-running 200 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Busy run length and pulse count; a pulse longer than one cycle counts once for each cycle.
    always @(posedge aclk) begin
        run_len <= (converter_busy === 1'b1) ? run_len + 11'h001 : 11'h000;
        if (converter_busy === 1'b1) last_len <= run_len + 11'h001;
        if (conversion_done_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write one word; address and data are released one by one as each is taken.
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        logic aw_left;
        logic w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (awready === 1'b1) aw_left = 1'b0;
            if (wready === 1'b1) w_left = 1'b0;
            awvalid <= aw_left;
            wvalid <= w_left;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp_q = bresp;
    endtask

    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd_q = rdata[7:0];
        resp_q = rresp;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
        axr(a);
        chk(rd_q & mask, exp);
    endtask

    // Let busy land, check the ladder mid-run, then wait for the end.
    task automatic conv_wait();
        @(posedge aclk);
        chk(ladder_connect, 1'b1);
        while (converter_busy === 1'b1) @(posedge aclk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdchk(`SAC_ADDR_CTL_ONE, 8'h10, 8'hff);
        rdchk(`SAC_ADDR_CTL_TWO, 8'h10, 8'h3f);
        rdchk(`SAC_ADDR_STATUS, 8'h00, 8'h30);
        axw(`SAC_ADDR_RESULT, 8'h55);
        rdchk(`SAC_ADDR_RESULT, 8'h00, 8'hff);
        axr(8'h40);
        chk(resp_q, `SAC_RESP_DECERR);
        axw(8'h44, 8'h00);
        chk(resp_q, `SAC_RESP_DECERR);
        axw(`SAC_ADDR_CTL_ONE, 8'h29);
        chk({channel_select, channel_valid, analog_input_off}, 6'h24);
    endtask

    // Every time code with its own channel; checks timing, flags, result and pulse.
    task automatic t_codes();
        logic [3:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[3:0];
            axw(`SAC_ADDR_CTL_TWO, {2'b00, c[0], 1'b1, c[2:0], 1'b0});
            axw(`SAC_ADDR_CTL_ONE, {4'b1010, c});
            chk({channel_select, channel_valid}, {c, 1'b1});
            rdchk(`SAC_ADDR_CTL_ONE, {4'b0010, c}, 8'hff);
            rdchk(`SAC_ADDR_STATUS, 8'h10, 8'h30);
            conv_wait();
            rdchk(`SAC_ADDR_STATUS, 8'h20, 8'h30);
            chk(last_len, conv_len[7 - i]);
            chk(irq_cnt, exp_k + 1);
            chk(ladder_connect, c[0]);
            rdchk(`SAC_ADDR_RESULT, {c, exp_k[3:0]}, 8'hff);
            exp_k++;
            rdchk(`SAC_ADDR_STATUS, 8'h00, 8'h30);
        end
    endtask

    // Restart without reading: flag drops, old result stays until the new one lands.
    task automatic t_restart();
        logic [7:0] old;
        axw(`SAC_ADDR_CTL_TWO, 8'h10);
        axw(`SAC_ADDR_CTL_ONE, 8'ha5);
        conv_wait();
        old = {4'h5, exp_k[3:0]};
        exp_k++;
        axw(`SAC_ADDR_CTL_ONE, 8'ha6);
        rdchk(`SAC_ADDR_STATUS, 8'h10, 8'h30);
        rdchk(`SAC_ADDR_RESULT, old, 8'hff);
        conv_wait();
        rdchk(`SAC_ADDR_RESULT, {4'h6, exp_k[3:0]}, 8'hff);
        exp_k++;
    endtask

    // Low power mid-run: abandon, reset controls, refuse writes, no restart.
    task automatic t_lowpower();
        axw(`SAC_ADDR_CTL_TWO, 8'h3c);
        axw(`SAC_ADDR_CTL_ONE, 8'ha2);
        repeat (20) @(posedge aclk);
        low_power_mode <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(converter_busy, 1'b0);
        axw(`SAC_ADDR_CTL_ONE, 8'h27);
        rdchk(`SAC_ADDR_CTL_ONE, 8'h10, 8'hff);
        rdchk(`SAC_ADDR_CTL_TWO, 8'h10, 8'h3f);
        chk(ladder_connect, 1'b0);
        low_power_mode <= 1'b0;
        repeat (1300) @(posedge aclk);
        chk(irq_cnt, exp_k);
        rdchk(`SAC_ADDR_STATUS, 8'h00, 8'h30);
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence; ready lines stay high so each answer is taken when it appears.
    initial begin
        {aresetn, awvalid, wvalid, arvalid, low_power_mode} = 5'h00;
        {bready, rready} = 2'b11;
        {awaddr, araddr, wdata, wstrb} = 52'h0000000000001;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_codes();
        t_restart();
        t_lowpower();
        give_verdict();
    end

    // Watchdog sized well beyond the longest run of all scenarios.
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        give_verdict();
    end
endmodule
